// file: cmd_defines.svh
// Opcodes, CDB field positions, status and sense codes, and reset values for the local command block.
// Assumes nothing beyond a SystemVerilog compiler; included by its bare name.
`ifndef CMD_DEFINES_SVH
`define CMD_DEFINES_SVH
`define OP_IST 8'hc9
`define OP_LINES 8'hc3
`define OP_LISTEN 8'hd2
`define OP_LOCAL 8'hca
`define OP_INQUIRY 8'h12
`define CDB_LEN 3'h6
`define PAD_HI 7
`define PAD_LO 3
`define SVALID_BIT 2
`define MODE_BIT 0
`define SAD_ALL 5'h1f
`define INQ_LEN 6'h31
`define ST_GOOD 8'h00
`define ST_CHECK 8'h02
`define MSG_DONE 8'h00
`define SK_NONE 4'h0
`define SK_ILLEGAL 4'h5
`define SK_ERROR 4'hb
`define IST_RESET 1'b0
`endif

// file: cmd_pkg.sv
// Types shared by the command block: information transfer phases and sequencer states.
// Assumes the defines header is compiled alongside.
package cmd_pkg;
  typedef enum logic [2:0]
  {
    PH_BUS_FREE = 3'h0,
    PH_COMMAND = 3'h1,
    PH_DATA_IN = 3'h2,
    PH_STATUS = 3'h3,
    PH_MSG_IN = 3'h4
  } phase_e;
  typedef enum logic [3:0]
  {
    S_IDLE = 4'h0,
    S_CDB = 4'h1,
    S_DECODE = 4'h2,
    S_CTRL = 4'h3,
    S_WAIT_GPIB = 4'h4,
    S_DATA = 4'h5,
    S_STATUS = 4'h6,
    S_MSG = 4'h7
  } state_e;
endpackage

// file: data_rom.sv
`timescale 1ns/1ns
// Small inquiry data store; the read byte comes out of a register.
// Assumes one synchronous clock; addresses past the stored bytes read as zero.
module data_rom #(
  parameter int DEPTH = 49
)
(
  // Clock.
  input wire logic clk_sys,
  // Read port.
  input wire logic [5:0] addr,
  output logic [7:0] rdata
);
  logic [7:0] rdata_nxt;

  // Fixed contents; vendor and product bytes are arbitrary neutral text.
  always_comb
  begin
    case (addr)
      6'h00: rdata_nxt = 8'h9f;
      6'h02: rdata_nxt = 8'h01;
      6'h03: rdata_nxt = 8'h02;
      6'h04: rdata_nxt = 8'h2c;
      6'h27: rdata_nxt = 8'h08;
      6'h29: rdata_nxt = 8'h04;
      6'h2b: rdata_nxt = 8'h06;
      6'h2c, 6'h2d, 6'h2e, 6'h2f, 6'h30: rdata_nxt = 8'hff;
      default: rdata_nxt = ((addr >= 6'h08) && (addr <= 6'h23)) ? 8'h20 : 8'h00;
    endcase
  end

  // Registered read: data appears one cycle after the address.
  always_ff @(posedge clk_sys)
  begin
    rdata <= rdata_nxt;
  end
endmodule

// file: local_cmd.sv
`timescale 1ns/1ns
`include "cmd_defines.svh"
// Interpreter for the status-bit, line query, listener check, go-to-local and inquiry commands.
// Assumes a SCSI byte engine in front that hands CDB bytes in and takes data bytes out with valid/ready,
// and a GPIB engine behind that carries out controller actions and answers with a done pulse.

module local_cmd (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // CDB bytes from the SCSI engine after selection.
  input wire logic cdb_valid,
  input wire logic [7:0] cdb_byte,
  output logic cdb_ready,
  // Data In bytes toward the initiator.
  output logic din_valid,
  output logic [7:0] din_byte,
  input wire logic din_ready,
  // Status and message bytes.
  output logic stat_valid,
  output logic [7:0] stat_byte,
  input wire logic stat_ready,
  output logic msg_valid,
  output logic [7:0] msg_byte,
  input wire logic msg_ready,
  output logic [2:0] phase,
  output logic [3:0] sense_key,
  // GPIB side: line readings, controller state and requests.
  input wire logic [7:0] line_state,
  input wire logic [7:0] line_valid,
  input wire logic cic,
  input wire logic sys_ctrl_en,
  output logic ifc_req,
  output logic ren_req,
  output logic gtl_req,
  output logic listen_req,
  output logic [4:0] pad,
  output logic [4:0] sad,
  output logic sad_valid,
  output logic sad_any,
  input wire logic gpib_done,
  input wire logic listener_found,
  output logic rtl_pulse,
  output logic ist
);
  logic [7:0] cdb_r [6];
  logic [7:0] cdb_nxt [6];
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [5:0] left_r;
  logic [5:0] left_nxt;
  logic [5:0] idx_r;
  logic [5:0] idx_nxt;
  cmd_pkg::state_e st_r;
  cmd_pkg::state_e st_nxt;
  logic ist_r;
  logic ist_nxt;
  logic ctrl_up_r;
  logic ctrl_up_nxt;
  logic [3:0] sense_r;
  logic [3:0] sense_nxt;
  logic [7:0] stat_r;
  logic [7:0] stat_nxt;
  logic [7:0] res_r;
  logic [7:0] res_nxt;
  logic [7:0] din_r;
  logic [7:0] din_nxt;
  logic rtl_r;
  logic rtl_nxt;
  logic rom_wait_r;
  logic rom_wait_nxt;
  logic [7:0] rom_data;
  logic [7:0] op;
  logic self_target_flag;

  // Bit 2 of byte 2 flags a valid secondary address.
  function automatic logic stray_sad(input logic [7:0] b2);
    stray_sad = !b2[`SVALID_BIT] && (b2[`PAD_HI:`PAD_LO] != 5'h00);
  endfunction

  // The store is addressed with the next index, so the byte for idx_r is already registered in the cycle
  // that idx_r moves; addressing with idx_r would hand out the byte of the previous index.
  data_rom #(.DEPTH(49)) u_rom (
    .clk_sys(clk_sys),
    .addr(idx_nxt),
    .rdata(rom_data)
  );

  // Only the fields below and byte 4 (the inquiry length, read in the sequencer) are decoded; everything else in the CDB is left alone.
  assign op = cdb_r[0];
  assign self_target_flag = cdb_r[3][`MODE_BIT];
  assign pad = cdb_r[1][`PAD_HI:`PAD_LO];
  assign sad = cdb_r[2][`PAD_HI:`PAD_LO];
  assign sad_valid = cdb_r[2][`SVALID_BIT];
  assign sad_any = sad_valid && (sad == `SAD_ALL);
  assign ist = ist_r;
  assign sense_key = sense_r;
  assign rtl_pulse = rtl_r;
  assign din_byte = din_r;
  assign stat_byte = stat_r;
  assign msg_byte = `MSG_DONE;

  // Handshakes and GPIB requests are decoded from the state.
  always_comb
  begin
    cdb_ready = (st_r == cmd_pkg::S_CDB);
    din_valid = (st_r == cmd_pkg::S_DATA) && !rom_wait_r;
    stat_valid = (st_r == cmd_pkg::S_STATUS);
    msg_valid = (st_r == cmd_pkg::S_MSG);
    ifc_req = (st_r == cmd_pkg::S_CTRL);
    ren_req = (st_r == cmd_pkg::S_CTRL);
    gtl_req = (st_r == cmd_pkg::S_WAIT_GPIB) && (op == `OP_LOCAL);
    listen_req = (st_r == cmd_pkg::S_WAIT_GPIB) && (op == `OP_LISTEN);
    case (st_r)
      cmd_pkg::S_IDLE: phase = cmd_pkg::PH_BUS_FREE;
      cmd_pkg::S_DATA: phase = cmd_pkg::PH_DATA_IN;
      cmd_pkg::S_STATUS: phase = cmd_pkg::PH_STATUS;
      cmd_pkg::S_MSG: phase = cmd_pkg::PH_MSG_IN;
      default: phase = cmd_pkg::PH_COMMAND;
    endcase
  end

  // Next-state logic for the command sequencer.
  always_comb
  begin
    st_nxt = st_r;
    cdb_nxt = cdb_r;
    cnt_nxt = cnt_r;
    left_nxt = left_r;
    idx_nxt = idx_r;
    ist_nxt = ist_r;
    ctrl_up_nxt = ctrl_up_r;
    sense_nxt = sense_r;
    stat_nxt = stat_r;
    res_nxt = res_r;
    din_nxt = din_r;
    rtl_nxt = 1'b0;
    rom_wait_nxt = 1'b0;
    case (st_r)
      cmd_pkg::S_IDLE:
      begin
        cnt_nxt = 3'h0;
        if (cdb_valid)
        begin
          st_nxt = cmd_pkg::S_CDB;
        end
      end
      cmd_pkg::S_CDB:
      begin
        if (cdb_valid)
        begin
          cdb_nxt[cnt_r] = cdb_byte;
          cnt_nxt = cnt_r + 3'h1;
          if (cnt_r == `CDB_LEN - 3'h1)
          begin
            st_nxt = cmd_pkg::S_DECODE;
          end
        end
      end
      cmd_pkg::S_DECODE:
      begin
        stat_nxt = `ST_GOOD;
        sense_nxt = `SK_NONE;
        idx_nxt = 6'h00;
        st_nxt = cmd_pkg::S_DATA;
        case (op)
          `OP_IST:
          begin
            ist_nxt = cdb_r[3][`MODE_BIT];
            din_nxt = 8'h00;
            left_nxt = 6'h00;
            st_nxt = cmd_pkg::S_STATUS;
          end
          `OP_LINES:
          begin
            din_nxt = line_state;
            res_nxt = line_valid;
            left_nxt = 6'h02;
          end
          `OP_INQUIRY:
          begin
            // Length is the lesser of the request and the stored data.
            left_nxt = (cdb_r[4] > {2'h0, `INQ_LEN}) ? `INQ_LEN : cdb_r[4][5:0];
            rom_wait_nxt = 1'b1;
            if (cdb_r[4] == 8'h00)
            begin
              st_nxt = cmd_pkg::S_STATUS;
            end
          end
          `OP_LISTEN, `OP_LOCAL:
          begin
            left_nxt = (op == `OP_LISTEN) ? 6'h01 : 6'h00;
            if (op == `OP_LOCAL && self_target_flag)
            begin
              rtl_nxt = 1'b1;
              st_nxt = cmd_pkg::S_STATUS;
            end
            else if (stray_sad(cdb_r[2]))
            begin
              stat_nxt = `ST_CHECK;
              sense_nxt = `SK_ILLEGAL;
              st_nxt = cmd_pkg::S_STATUS;
            end
            else if (!ctrl_up_r && sys_ctrl_en)
            begin
              st_nxt = cmd_pkg::S_CTRL;
            end
            else if (!cic)
            begin
              stat_nxt = `ST_CHECK;
              sense_nxt = `SK_ERROR;
              st_nxt = cmd_pkg::S_STATUS;
            end
            else
            begin
              st_nxt = cmd_pkg::S_WAIT_GPIB;
            end
          end
          default:
          begin
            stat_nxt = `ST_CHECK;
            sense_nxt = `SK_ILLEGAL;
            st_nxt = cmd_pkg::S_STATUS;
          end
        endcase
      end
      cmd_pkg::S_CTRL:
      begin
        // IFC and REN are sent once; the engine reports completion.
        if (gpib_done)
        begin
          ctrl_up_nxt = 1'b1;
          st_nxt = cmd_pkg::S_WAIT_GPIB;
        end
      end
      cmd_pkg::S_WAIT_GPIB:
      begin
        if (gpib_done)
        begin
          din_nxt = {7'h00, listener_found};
          st_nxt = (op == `OP_LISTEN) ? cmd_pkg::S_DATA : cmd_pkg::S_STATUS;
        end
      end
      cmd_pkg::S_DATA:
      begin
        if (rom_wait_r)
        begin
          din_nxt = rom_data;
        end
        else if (din_ready)
        begin
          left_nxt = left_r - 6'h01;
          idx_nxt = idx_r + 6'h01;
          din_nxt = res_r; // Second byte of the line query is the mask.
          rom_wait_nxt = (op == `OP_INQUIRY);
          if (left_r == 6'h01)
          begin
            st_nxt = cmd_pkg::S_STATUS;
          end
        end
      end
      cmd_pkg::S_STATUS:
      begin
        if (stat_ready)
        begin
          st_nxt = cmd_pkg::S_MSG;
        end
      end
      cmd_pkg::S_MSG:
      begin
        if (msg_ready)
        begin
          st_nxt = cmd_pkg::S_IDLE;
        end
      end
      default: st_nxt = cmd_pkg::S_IDLE;
    endcase
  end

  // Registers only; the sequencer and ist start clear.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_r <= cmd_pkg::S_IDLE;
      cdb_r <= '{default: 8'h00};
      cnt_r <= 3'h0;
      left_r <= 6'h00;
      idx_r <= 6'h00;
      ist_r <= `IST_RESET;
      ctrl_up_r <= 1'b0;
      sense_r <= `SK_NONE;
      stat_r <= `ST_GOOD;
      res_r <= 8'h00;
      din_r <= 8'h00;
      rtl_r <= 1'b0;
      rom_wait_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cdb_r <= cdb_nxt;
      cnt_r <= cnt_nxt;
      left_r <= left_nxt;
      idx_r <= idx_nxt;
      ist_r <= ist_nxt;
      ctrl_up_r <= ctrl_up_nxt;
      sense_r <= sense_nxt;
      stat_r <= stat_nxt;
      res_r <= res_nxt;
      din_r <= din_nxt;
      rtl_r <= rtl_nxt;
      rom_wait_r <= rom_wait_nxt;
    end
  end

  sequence s_local_cmd;
    st_r == cmd_pkg::S_DECODE && op == `OP_LOCAL;
  endsequence

  a_ist_update: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == cmd_pkg::S_DECODE && op == `OP_IST) |=> ist == $past(cdb_r[3][0]))
    else $error("ist did not follow mode bit");
  a_ist_reset: assert property (@(posedge clk_sys)
    !rst_n |=> !ist) else $error("ist not clear after reset");
  a_lines_two: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == cmd_pkg::S_DECODE && op == `OP_LINES) |=> left_r == 6'h02)
    else $error("line query length wrong");
  a_lines_byte: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == cmd_pkg::S_DECODE && op == `OP_LINES) |=> din_byte == $past(line_state) && res_r == $past(line_valid))
    else $error("line bytes wrong");
  a_stray_sad: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == cmd_pkg::S_DECODE && op == `OP_LISTEN && stray_sad(cdb_r[2]))
    |=> stat_r == `ST_CHECK && sense_r == `SK_ILLEGAL && st_r == cmd_pkg::S_STATUS)
    else $error("stray secondary not rejected");
  a_self_rtl: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_local_cmd ##0 self_target_flag |=> rtl_pulse ##1 !rtl_pulse)
    else $error("rtl not pulsed once");
  a_self_noctrl: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_local_cmd ##0 self_target_flag |=> !ifc_req && !gtl_req && stat_r == `ST_GOOD)
    else $error("self local needed controller");
  a_not_cic: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_local_cmd ##0 (!self_target_flag && !stray_sad(cdb_r[2]) && !cic && (ctrl_up_r || !sys_ctrl_en)))
    |=> sense_r == `SK_ERROR) else $error("not in charge not rejected");
  a_local_nodata: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (op == `OP_LOCAL && st_r != cmd_pkg::S_DECODE) |-> !din_valid)
    else $error("data phase on go-to-local");
  a_inq_cap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == cmd_pkg::S_DECODE && op == `OP_INQUIRY) |=> left_r <= `INQ_LEN)
    else $error("inquiry length above cap");
endmodule

// file: gpib_model.sv
`timescale 1ns/1ns
// Behavioural stand-in for the GPIB engine and the instruments on the bus.
// Assumes requests are levels held until the done pulse, as the interpreter drives them.
module gpib_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Requests from the interpreter; drop_cic comes from the bench.
  input wire logic ifc_req,
  input wire logic gtl_req,
  input wire logic listen_req,
  input wire logic [4:0] pad,
  input wire logic [4:0] sad,
  input wire logic sad_valid,
  input wire logic sad_any,
  input wire logic drop_cic,
  // Answers and counts for the bench.
  output logic gpib_done,
  output logic listener_found,
  output logic cic,
  output logic [3:0] ifc_cnt,
  output logic [3:0] gtl_cnt
);
  logic [3:0] wait_r;
  logic slow_r;
  logic hit;
  // One instrument listens at primary 1, at secondary 2 or with no secondary.
  assign hit = pad == 5'h01 && (!sad_valid || sad_any || sad == 5'h02);
  // Answers alternate prompt and slow; the found line toggles outside the done
  // cycle, so a late sample reads noise instead of a lucky value.
  always_ff @(posedge clk_sys)
  begin
    gpib_done <= 1'b0;
    listener_found <= ~listener_found;
    if (drop_cic)
      cic <= 1'b0;
    if (!rst_n)
    begin
      wait_r <= 4'h0;
      slow_r <= 1'b0;
      cic <= 1'b0;
      ifc_cnt <= 4'h0;
      gtl_cnt <= 4'h0;
      listener_found <= 1'b0;
    end
    else if ((ifc_req || gtl_req || listen_req) && !gpib_done)
    begin
      wait_r <= wait_r + 4'h1;
      if (wait_r == (slow_r ? 4'h5 : 4'h1))
      begin
        wait_r <= 4'h0;
        slow_r <= ~slow_r;
        gpib_done <= 1'b1;
        listener_found <= hit;
        if (ifc_req)
        begin
          cic <= 1'b1;
          ifc_cnt <= ifc_cnt + 4'h1;
        end
        if (gtl_req)
          gtl_cnt <= gtl_cnt + 4'h1;
      end
    end
  end
endmodule

// file: tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the local command interpreter.
// Assumes the design files and the bus model are compiled first.
module tb_top;
  typedef struct packed
  {
    logic [47:0] cdb;
    logic [5:0] nd;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] st;
    logic [3:0] sk;
    logic rtl;
    logic ist;
  } row_s;
  row_s rows[12];
  int bad_count = 0;
  int checks_done = 0;
  int i;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cdb_valid = 1'b0;
  logic [7:0] cdb_byte = 8'h00;
  logic din_ready = 1'b1;
  logic stat_ready = 1'b1;
  logic msg_ready = 1'b1;
  logic [7:0] line_state = 8'ha5;
  logic [7:0] line_valid = 8'h3c;
  logic sys_ctrl_en = 1'b1;
  logic drop_cic = 1'b0;
  logic stall = 1'b0;
  logic cdb_ready, din_valid, stat_valid, msg_valid, cic, ifc_req, ren_req;
  logic gtl_req, listen_req, sad_valid, sad_any, gpib_done, listener_found;
  logic rtl_pulse, ist;
  logic [7:0] din_byte, stat_byte, msg_byte;
  logic [2:0] phase;
  logic [3:0] sense_key, ifc_cnt, gtl_cnt;
  logic [4:0] pad, sad;

  local_cmd dut_u (.clk_sys, .rst_n, .cdb_valid, .cdb_byte, .cdb_ready, .din_valid,
    .din_byte, .din_ready, .stat_valid, .stat_byte, .stat_ready, .msg_valid,
    .msg_byte, .msg_ready, .phase, .sense_key, .line_state, .line_valid, .cic,
    .sys_ctrl_en, .ifc_req, .ren_req, .gtl_req, .listen_req, .pad, .sad,
    .sad_valid, .sad_any, .gpib_done, .listener_found, .rtl_pulse, .ist);
  gpib_model partner_u (.clk_sys, .rst_n, .ifc_req, .gtl_req, .listen_req, .pad,
    .sad, .sad_valid, .sad_any, .drop_cic, .gpib_done, .listener_found, .cic,
    .ifc_cnt, .gtl_cnt);

  // The clock and the stalling initiator; a toggling ready tests held data.
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    din_ready <= stall ? ~din_ready : 1'b1;

  // Prints the counts and the verdict, then stops the run.
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Compares one value and counts the outcome.
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Sends one CDB, then drains data, status and message, all with bounded waits.
  task automatic run_row(input row_s r);
    int n, rtl_seen, k, t;
    logic done;
    logic [7:0] got[2];
    n = 0;
    rtl_seen = 0;
    done = 1'b0;
    got[0] = 8'h00;
    got[1] = 8'h00;
    for (k = 0; k < 6; k++)
    begin
      cdb_valid <= 1'b1;
      cdb_byte <= r.cdb[47 - 8 * k -: 8];
      for (t = 0; t <= 20 && !done; t++)
      begin
        @(negedge clk_sys);
        done = cdb_ready;
        @(posedge clk_sys);
      end
      if (!done)
      begin
        bad_count++;
        close_out();
      end
      done = 1'b0;
    end
    cdb_valid <= 1'b0;
    for (t = 0; t < 400 && !done; t++)
    begin
      @(negedge clk_sys);
      if (rtl_pulse === 1'b1)
        rtl_seen++;
      if (ifc_req === 1'b1)
        cmp_val({7'h0, ren_req}, 8'h01);
      if (din_valid === 1'b1 && din_ready)
      begin
        if (n < 2)
          got[n] = din_byte;
        n++;
        cmp_val({5'h0, phase}, 8'h02);
      end
      if (stat_valid === 1'b1)
      begin
        cmp_val(stat_byte, r.st);
        cmp_val({4'h0, sense_key}, {4'h0, r.sk});
        cmp_val({5'h0, phase}, 8'h03);
      end
      if (msg_valid === 1'b1)
      begin
        cmp_val(msg_byte, 8'h00);
        cmp_val({5'h0, phase}, 8'h04);
        done = 1'b1;
      end
      @(posedge clk_sys);
    end
    if (!done)
    begin
      bad_count++;
      close_out();
    end
    cmp_val(n[7:0], {2'h0, r.nd});
    if (r.nd > 0)
      cmp_val(got[0], r.d0);
    if (r.nd > 1)
      cmp_val(got[1], r.d1);
    cmp_val(rtl_seen[7:0], {7'h0, r.rtl});
    cmp_val({7'h0, ist}, {7'h0, r.ist});
  endtask

  // Main sequence: reset, the table, then the controller, inquiry and reset cases.
  initial
  begin
    rows[0] = {48'hc9_00_00_01_00_00, 6'h00, 8'h00, 8'h00, 8'h00, 4'h0, 1'b0, 1'b1};
    rows[1] = {48'hc3_00_00_00_00_00, 6'h02, 8'ha5, 8'h3c, 8'h00, 4'h0, 1'b0, 1'b1};
    rows[2] = {48'hd2_08_fc_00_00_00, 6'h01, 8'h01, 8'h00, 8'h00, 4'h0, 1'b0, 1'b1};
    rows[3] = {48'hd2_08_14_00_00_00, 6'h01, 8'h01, 8'h00, 8'h00, 4'h0, 1'b0, 1'b1};
    rows[4] = {48'hd2_18_00_00_00_00, 6'h01, 8'h00, 8'h00, 8'h00, 4'h0, 1'b0, 1'b1};
    rows[5] = {48'hd2_08_10_00_00_00, 6'h00, 8'h00, 8'h00, 8'h02, 4'h5, 1'b0, 1'b1};
    rows[6] = {48'hca_08_14_00_00_00, 6'h00, 8'h00, 8'h00, 8'h00, 4'h0, 1'b0, 1'b1};
    rows[7] = {48'hca_f8_10_01_00_00, 6'h00, 8'h00, 8'h00, 8'h00, 4'h0, 1'b1, 1'b1};
    rows[8] = {48'hc9_ff_ff_fe_ff_ff, 6'h00, 8'h00, 8'h00, 8'h00, 4'h0, 1'b0, 1'b0};
    rows[9] = {48'h12_00_00_00_02_00, 6'h02, 8'h9f, 8'h00, 8'h00, 4'h0, 1'b0, 1'b0};
    rows[10] = {48'h12_00_00_00_31_00, 6'h31, 8'h9f, 8'h00, 8'h00, 4'h0, 1'b0, 1'b0};
    rows[11] = {48'h00_00_00_00_00_00, 6'h00, 8'h00, 8'h00, 8'h02, 4'h5, 1'b0, 1'b0};
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    cmp_val({7'h0, ist}, 8'h00);
    cmp_val({5'h0, phase}, 8'h00);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    stall <= 1'b1;
    for (i = 0; i < 12; i++)
    begin
      run_row(rows[i]);
      $display("test %0d done", i);
    end
    stall <= 1'b0;
    cmp_val({4'h0, ifc_cnt}, 8'h01);
    cmp_val({4'h0, gtl_cnt}, 8'h01);
    // Control passed away: remote local is refused, self local still works.
    drop_cic <= 1'b1;
    run_row({48'hca_08_14_00_00_00, 6'h00, 8'h00, 8'h00, 8'h02, 4'hb, 1'b0, 1'b0});
    run_row({48'hca_f8_10_01_00_00, 6'h00, 8'h00, 8'h00, 8'h00, 4'h0, 1'b1, 1'b0});
    // Inquiry with no allocation gives no data; an oversized one stops at the stored length.
    run_row({48'h12_00_00_00_00_00, 6'h00, 8'h00, 8'h00, 8'h00, 4'h0, 1'b0, 1'b0});
    run_row({48'h12_00_00_00_40_00, 6'h31, 8'h9f, 8'h00, 8'h00, 4'h0, 1'b0, 1'b0});
    $display("test %0d done", 12);
    // Reset in mid-run with system control off: ist clears, no IFC is sent.
    drop_cic <= 1'b0;
    run_row(rows[0]);
    sys_ctrl_en <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    run_row({48'hca_08_14_00_00_00, 6'h00, 8'h00, 8'h00, 8'h02, 4'hb, 1'b0, 1'b0});
    cmp_val({4'h0, ifc_cnt}, 8'h00);
    $display("test %0d done", 13);
    close_out();
  end
endmodule
